// ===== hw/sps_port.sv
`timescale 1ns/1ps
// Stream slave port feeding a stream master port through a
// two-entry buffer. Omitted sideband inputs are replaced by their
// fixed values, so the downstream side always sees a full port.
module sps_port #(
  parameter int DATA_W      = 32,
  parameter int ID_W        = 4,
  parameter int DEST_W      = 4,
  parameter int USER_W      = 1,
  parameter bit HAS_TDATA   = 1'h1,
  parameter bit HAS_TKEEP   = 1'h1,
  parameter bit HAS_TSTRB   = 1'h1,
  parameter bit HAS_TLAST   = 1'h1,
  parameter bit HAS_TID     = 1'h1,
  parameter bit HAS_TDEST   = 1'h1,
  parameter bit HAS_TUSER   = 1'h1,
  parameter bit HAS_M_READY = 1'h1
) (
  input  wire logic                i_mclk,
  input  wire logic                i_nrst,
  input  wire logic                i_s_tvalid,
  output logic                     o_s_tready,
  input  wire logic [DATA_W-1:0]   i_s_tdata,
  input  wire logic [DATA_W/8-1:0] i_s_tkeep,
  input  wire logic [DATA_W/8-1:0] i_s_tstrb,
  input  wire logic                i_s_tlast,
  input  wire logic [ID_W-1:0]     i_s_tid,
  input  wire logic [DEST_W-1:0]   i_s_tdest,
  input  wire logic [USER_W-1:0]   i_s_tuser,
  output logic                     o_m_tvalid,
  input  wire logic                i_m_tready,
  output logic [DATA_W-1:0]        o_m_tdata,
  output logic [DATA_W/8-1:0]      o_m_tkeep,
  output logic [DATA_W/8-1:0]      o_m_tstrb,
  output logic                     o_m_tlast,
  output logic [ID_W-1:0]          o_m_tid,
  output logic [DEST_W-1:0]        o_m_tdest,
  output logic [USER_W-1:0]        o_m_tuser,
  input  wire logic                i_err_clr,
  output logic                     o_err_null_bytes,
  output logic                     o_warn_strb_rem,
  output logic                     o_in_packet,
  output logic [31:0]              o_beat_count,
  output logic [31:0]              o_pkt_count
);
  localparam int KEEP_W = DATA_W / sps_pkg::BYTE_W;
  localparam int PAY_W  = DATA_W + 2 * KEEP_W + 1 + ID_W + DEST_W + USER_W;
  localparam int O_KEEP = DATA_W;
  localparam int O_STRB = O_KEEP + KEEP_W;
  localparam int O_LAST = O_STRB + KEEP_W;
  localparam int O_ID   = O_LAST + 1;
  localparam int O_DEST = O_ID + ID_W;
  localparam int O_USER = O_DEST + DEST_W;

  // Effective input fields after substitution of omitted signals
  wire [DATA_W-1:0] eff_data;
  wire [KEEP_W-1:0] eff_keep;
  wire [KEEP_W-1:0] eff_strb;
  wire              eff_last;
  wire [ID_W-1:0]   eff_id;
  wire [DEST_W-1:0] eff_dest;
  wire [USER_W-1:0] eff_user;
  wire              m_ready_eff;
  wire              s_fire;
  wire              m_fire;
  wire [PAY_W-1:0]  pay_in;
  wire [PAY_W-1:0]  pay_out;

  assign eff_data = HAS_TDATA ? i_s_tdata
                              : {DATA_W{sps_pkg::DFLT_ZERO_BIT}};
  assign eff_keep = HAS_TKEEP ? i_s_tkeep
                              : {KEEP_W{sps_pkg::DFLT_ONE_BIT}};
  // Omitted strobe follows keep, which is itself all ones if omitted
  assign eff_strb = HAS_TSTRB ? i_s_tstrb : eff_keep;
  assign eff_last = HAS_TLAST ? i_s_tlast : sps_pkg::DFLT_LAST;
  assign eff_id   = HAS_TID ? i_s_tid
                            : {ID_W{sps_pkg::DFLT_ZERO_BIT}};
  assign eff_dest = HAS_TDEST ? i_s_tdest
                              : {DEST_W{sps_pkg::DFLT_ZERO_BIT}};
  assign eff_user = HAS_TUSER ? i_s_tuser
                              : {USER_W{sps_pkg::DFLT_ZERO_BIT}};
  assign m_ready_eff = HAS_M_READY ? i_m_tready : sps_pkg::DFLT_READY;

  // A beat counts only in the cycle both sides agree
  assign s_fire = i_s_tvalid & o_s_tready;
  assign m_fire = o_m_tvalid & m_ready_eff;

  assign pay_in = {eff_user, eff_dest, eff_id, eff_last,
                   eff_strb, eff_keep, eff_data};

  // Payload flows one way only; the buffer never limits run length
  sps_skid #(
    .W (PAY_W)
  ) u_buf (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_valid (i_s_tvalid),
    .o_ready (o_s_tready),
    .i_data  (pay_in),
    .o_valid (o_m_tvalid),
    .i_ready (m_ready_eff),
    .o_data  (pay_out)
  );

  assign o_m_tdata = pay_out[O_KEEP-1:0];
  assign o_m_tkeep = pay_out[O_STRB-1:O_KEEP];
  assign o_m_tstrb = pay_out[O_LAST-1:O_STRB];
  assign o_m_tlast = pay_out[O_LAST];
  assign o_m_tid   = pay_out[O_DEST-1:O_ID];
  assign o_m_tdest = pay_out[O_USER-1:O_DEST];
  assign o_m_tuser = pay_out[PAY_W-1:O_USER];

  sps_rule_mon #(
    .KEEP_W (KEEP_W)
  ) u_mon (
    .i_mclk     (i_mclk),
    .i_nrst     (i_nrst),
    .i_beat     (s_fire),
    .i_keep     (eff_keep),
    .i_strb     (eff_strb),
    .i_last     (eff_last),
    .i_clr      (i_err_clr),
    .o_null_err (o_err_null_bytes),
    .o_rem_warn (o_warn_strb_rem)
  );

  // Packet bookkeeping; without a last flag no boundary ever exists
  wire        pkt_end = s_fire & eff_last & HAS_TLAST;
  wire [31:0] next_beat_count = o_beat_count + 32'h0000_0001;
  wire [31:0] next_pkt_count  = o_pkt_count + 32'h0000_0001;
  wire        next_in_packet  = HAS_TLAST & ~eff_last;

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_beat_count <= sps_pkg::CNT_RST;
      o_pkt_count  <= sps_pkg::CNT_RST;
      o_in_packet  <= 1'h0;
    end
    else
    begin
      if (s_fire)
        o_beat_count <= next_beat_count;
      if (pkt_end)
        o_pkt_count <= next_pkt_count;
      if (s_fire)
        o_in_packet <= next_in_packet;
    end
  end

  // Checks
  sequence s_accept_last;
    s_fire && eff_last;
  endsequence

  sequence s_stalled;
    o_m_tvalid && !m_ready_eff;
  endsequence

  sequence s_take_stalled;
    s_fire && o_m_tvalid && !m_ready_eff;
  endsequence

  sequence s_take_free;
    s_fire && !(o_m_tvalid && !m_ready_eff);
  endsequence

  property p_beat_on_handshake;
    @(posedge i_mclk) disable iff (!i_nrst)
      !s_fire |=> $stable(o_beat_count);
  endproperty
  a_beat_on_handshake: assert property (p_beat_on_handshake)
    else $error("beat counted without handshake");

  property p_stall_keeps_beat;
    @(posedge i_mclk) disable iff (!i_nrst)
      s_stalled |=> o_m_tvalid && $stable(o_m_tdata) && $stable(o_m_tlast);
  endproperty
  a_stall_keeps_beat: assert property (p_stall_keeps_beat)
    else $error("held beat changed before handshake");

  property p_no_run_limit;
    @(posedge i_mclk) disable iff (!i_nrst)
      m_ready_eff [*2] |-> o_s_tready;
  endproperty
  a_no_run_limit: assert property (p_no_run_limit)
    else $error("input refused while output drains");

  property p_pkt_end_count;
    @(posedge i_mclk) disable iff (!i_nrst)
      s_accept_last |=> o_pkt_count == $past(o_pkt_count) + 32'h0000_0001
                        && !o_in_packet;
  endproperty
  a_pkt_end_count: assert property (p_pkt_end_count)
    else $error("packet end not counted");

  property p_continuous;
    @(posedge i_mclk) disable iff (!i_nrst)
      !HAS_TLAST |-> o_pkt_count == sps_pkg::CNT_RST && !o_in_packet
                     && (!o_m_tvalid || !o_m_tlast);
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("packet boundary seen on continuous stream");

  property p_data_default;
    @(posedge i_mclk) disable iff (!i_nrst)
      o_m_tvalid && !HAS_TDATA |-> o_m_tdata == '0;
  endproperty
  a_data_default: assert property (p_data_default)
    else $error("omitted data not zero");

  property p_widths;
    @(posedge i_mclk) disable iff (!i_nrst)
      1'h1 |-> DATA_W >= sps_pkg::DATA_W_MIN && DATA_W <= sps_pkg::DATA_W_MAX
        && ID_W >= sps_pkg::ROUTE_W_MIN && ID_W <= sps_pkg::ROUTE_W_MAX
        && DEST_W >= sps_pkg::ROUTE_W_MIN && DEST_W <= sps_pkg::ROUTE_W_MAX
        && USER_W >= sps_pkg::USER_W_MIN && USER_W <= sps_pkg::USER_W_MAX;
  endproperty
  a_widths: assert property (p_widths)
    else $error("port width out of range");

  property p_keep_default;
    @(posedge i_mclk) disable iff (!i_nrst)
      o_m_tvalid && !HAS_TKEEP |-> &o_m_tkeep;
  endproperty
  a_keep_default: assert property (p_keep_default)
    else $error("omitted keep not all ones");

  property p_strb_default;
    @(posedge i_mclk) disable iff (!i_nrst)
      o_m_tvalid && !HAS_TSTRB |-> o_m_tstrb == o_m_tkeep;
  endproperty
  a_strb_default: assert property (p_strb_default)
    else $error("omitted strobe does not follow keep");

  property p_route_default;
    @(posedge i_mclk) disable iff (!i_nrst)
      o_m_tvalid |-> (HAS_TID || o_m_tid == '0)
                     && (HAS_TDEST || o_m_tdest == '0);
  endproperty
  a_route_default: assert property (p_route_default)
    else $error("omitted id or dest not zero");

  property p_user_default;
    @(posedge i_mclk) disable iff (!i_nrst)
      o_m_tvalid && !HAS_TUSER |-> o_m_tuser == '0;
  endproperty
  a_user_default: assert property (p_user_default)
    else $error("omitted user not zero");

  property p_ready_absent;
    @(posedge i_mclk) disable iff (!i_nrst)
      !HAS_M_READY && o_m_tvalid && !s_fire |=> !o_m_tvalid;
  endproperty
  a_ready_absent: assert property (p_ready_absent)
    else $error("output stalled with no ready");

  // Reset leaves both handshakes quiet and every count at zero
  property p_reset_clean;
    @(posedge i_mclk)
      !i_nrst |=> !o_s_tready && !o_m_tvalid && !o_in_packet
                  && o_beat_count == sps_pkg::CNT_RST && o_pkt_count == sps_pkg::CNT_RST;
  endproperty
  a_reset_clean: assert property (p_reset_clean)
    else $error("state not cleared by reset");

  property p_count_step;
    @(posedge i_mclk) disable iff (!i_nrst)
      s_fire |=> o_beat_count == $past(o_beat_count) + 32'h0000_0001;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("accepted beat not counted");

  property p_show_next;
    @(posedge i_mclk) disable iff (!i_nrst)
      s_take_free |=> o_m_tvalid && o_m_tdata == $past(eff_data)
                      && o_m_tlast == $past(eff_last);
  endproperty
  a_show_next: assert property (p_show_next)
    else $error("accepted beat not shown next cycle");

  property p_fill_refuse;
    @(posedge i_mclk) disable iff (!i_nrst)
      s_take_stalled |=> !o_s_tready && o_m_tvalid;
  endproperty
  a_fill_refuse: assert property (p_fill_refuse)
    else $error("input still ready with both entries full");

  property p_skid_order;
    @(posedge i_mclk) disable iff (!i_nrst)
      s_take_stalled ##1 m_fire |=> o_m_tvalid && o_m_tdata == $past(eff_data, 2)
                                    && o_m_tlast == $past(eff_last, 2);
  endproperty
  a_skid_order: assert property (p_skid_order)
    else $error("parked beat lost or reordered");

  property p_ready_back;
    @(posedge i_mclk) disable iff (!i_nrst)
      !o_s_tready && m_ready_eff |=> o_s_tready;
  endproperty
  a_ready_back: assert property (p_ready_back)
    else $error("input not reopened after drain");

  property p_in_packet_set;
    @(posedge i_mclk) disable iff (!i_nrst)
      s_fire && HAS_TLAST && !eff_last |=> o_in_packet;
  endproperty
  a_in_packet_set: assert property (p_in_packet_set)
    else $error("open packet not marked");

  property p_pkt_steady;
    @(posedge i_mclk) disable iff (!i_nrst)
      !(s_fire && eff_last) |=> $stable(o_pkt_count);
  endproperty
  a_pkt_steady: assert property (p_pkt_steady)
    else $error("packet counted without a last beat");
endmodule : sps_port

// ===== hw/sps_pkg.sv
// Overview of operation
// - Beats move only on completed valid/ready handshake
// - One-way master-to-slave stream, no burst limit
// - Last marks packet end; absent last reads 0
// - Without last, stream is continuous, no packets
// - Absent data is zero; width 8 to 4096
// - Absent keep is ones; nulls only trailing; monitor checks a last beat only for a null byte 0
// - Absent strobe copies keep, else all ones
// - Absent id/dest are zero; width 1 to 32
// - Absent user is zero; width 1 to 4096
package sps_pkg;
  localparam int DATA_W_MIN = 8;
  localparam int DATA_W_MAX = 4096;
  localparam int ROUTE_W_MIN = 1;
  localparam int ROUTE_W_MAX = 32;
  localparam int USER_W_MIN = 1;
  localparam int USER_W_MAX = 4096;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 32;
  localparam logic DFLT_READY = 1'h1;
  localparam logic DFLT_LAST = 1'h0;
  localparam logic DFLT_ZERO_BIT = 1'h0;
  localparam logic DFLT_ONE_BIT = 1'h1;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
endpackage : sps_pkg

// ===== hw/sps_skid.sv
`timescale 1ns/1ps
// Two-entry buffer: output stage plus one skid slot, so ready is
// registered and a stall on the far side never drops a beat.
module sps_skid #(
  parameter int W = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_nrst,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  logic         skid_v;
  logic [W-1:0] skid;
  wire          in_fire  = i_valid & o_ready;
  wire          out_free = ~o_valid | i_ready;
  wire          next_skid_v = out_free ? 1'h0 : (skid_v | in_fire);

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_valid <= 1'h0;
      skid_v  <= 1'h0;
      o_ready <= 1'h0;
    end
    else
    begin
      if (out_free)
        o_valid <= skid_v | in_fire;
      skid_v  <= next_skid_v;
      o_ready <= ~next_skid_v;
    end
  end

  // Payload needs no reset; it is qualified by the valid flags
  always_ff @(posedge i_mclk)
  begin
    if (out_free && skid_v)
      o_data <= skid;
    else if (out_free && in_fire)
      o_data <= i_data;
    if (!out_free && in_fire && !skid_v)
      skid <= i_data;
  end

  property p_stall_hold;
    @(posedge i_mclk) disable iff (!i_nrst)
      o_valid && !i_ready |=> o_valid && $stable(o_data);
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("output beat changed while stalled");
endmodule : sps_skid

// ===== hw/sps_rule_mon.sv
`timescale 1ns/1ps
// Watches accepted beats for byte-qualifier misuse by the sender.
module sps_rule_mon #(
  parameter int KEEP_W = 4
) (
  input  wire logic              i_mclk,
  input  wire logic              i_nrst,
  input  wire logic              i_beat,
  input  wire logic [KEEP_W-1:0] i_keep,
  input  wire logic [KEEP_W-1:0] i_strb,
  input  wire logic              i_last,
  input  wire logic              i_clr,
  output logic                   o_null_err,
  output logic                   o_rem_warn
);
  logic sparse_seen;
  wire  keep_full  = &i_keep;
  wire  null_bad   = i_beat & ((~keep_full & ~i_last) | ~i_keep[0]);
  wire  sparse_now = i_strb != i_keep;
  wire  rem_only   = i_beat & i_last & sparse_now & ~sparse_seen;

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_null_err  <= 1'h0;
      o_rem_warn  <= 1'h0;
      sparse_seen <= 1'h0;
    end
    else
    begin
      // Set beats clear when both land in one cycle
      o_null_err <= null_bad | (o_null_err & ~i_clr);
      o_rem_warn <= rem_only | (o_rem_warn & ~i_clr);
      if (i_beat)
        sparse_seen <= ~i_last & (sparse_seen | sparse_now);
    end
  end

  property p_null_flag;
    @(posedge i_mclk) disable iff (!i_nrst)
      i_beat && !i_last && !keep_full |=> o_null_err;
  endproperty
  a_null_flag: assert property (p_null_flag)
    else $error("middle null byte not flagged");
endmodule : sps_rule_mon

// ===== test/sps_sink.sv
`timescale 1ns/1ps
// Downstream receiver. The bench sets the stall level, and every accepted beat is queued.
module sps_sink #(
  parameter int W = 50
) (
  input  wire logic         i_mclk,
  input  wire logic         i_stall,
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_beat,
  output logic              o_ready
);
  logic [W-1:0] got_q[$];

  initial o_ready = 1'h0;

  // Ready changes only between edges, never on the sampling edge
  always @(negedge i_mclk)
  begin
    o_ready <= ~i_stall;
  end

  // A beat counts only at an edge where both valid and ready are high
  always @(posedge i_mclk)
  begin
    if (i_valid && o_ready)
    begin
      got_q.push_back(i_beat);
    end
  end
endmodule : sps_sink

// ===== test/test_sps_port.sv
`timescale 1ns/1ps
module test_sps_port;
  localparam int BW = 50;
  localparam bit OMIT = 1'h0;
  logic        mclk, nrst, s_tvalid, s_tlast, err_clr, stall, s_tready, m_tvalid, m_tready;
  logic [31:0] s_tdata, m_tdata, n_tdata, beat_cnt, pkt_cnt, n_beat_cnt, n_pkt_cnt;
  logic [3:0]  s_tkeep, s_tstrb, s_tid, s_tdest, m_tkeep, m_tstrb, m_tid, m_tdest;
  logic [3:0]  n_tkeep, n_tstrb, n_tid, n_tdest;
  logic [0:0]  s_tuser, m_tuser, n_tuser;
  logic        m_tlast, err_null, warn_rem, in_pkt, n_tready, n_tvalid, n_tlast, n_in_pkt;
  logic [BW-1:0] exp_q[$];
  int          n_fail, total_checks, n_sent;

  sps_port i_sps_port (
    .i_mclk(mclk), .i_nrst(nrst), .i_s_tvalid(s_tvalid), .o_s_tready(s_tready),
    .i_s_tdata(s_tdata), .i_s_tkeep(s_tkeep), .i_s_tstrb(s_tstrb), .i_s_tlast(s_tlast),
    .i_s_tid(s_tid), .i_s_tdest(s_tdest), .i_s_tuser(s_tuser), .o_m_tvalid(m_tvalid),
    .i_m_tready(m_tready), .o_m_tdata(m_tdata), .o_m_tkeep(m_tkeep), .o_m_tstrb(m_tstrb),
    .o_m_tlast(m_tlast), .o_m_tid(m_tid), .o_m_tdest(m_tdest), .o_m_tuser(m_tuser),
    .i_err_clr(err_clr), .o_err_null_bytes(err_null), .o_warn_strb_rem(warn_rem),
    .o_in_packet(in_pkt), .o_beat_count(beat_cnt), .o_pkt_count(pkt_cnt));

  // Every sideband signal omitted and no downstream ready, fed from the same inputs;
  // its ready input follows the stall level and must be ignored
  sps_port #(.HAS_TDATA(OMIT), .HAS_TKEEP(OMIT), .HAS_TSTRB(OMIT), .HAS_TLAST(OMIT),
    .HAS_TID(OMIT), .HAS_TDEST(OMIT), .HAS_TUSER(OMIT), .HAS_M_READY(OMIT)) i_sps_port_min (
    .i_mclk(mclk), .i_nrst(nrst), .i_s_tvalid(s_tvalid), .o_s_tready(n_tready),
    .i_s_tdata(s_tdata), .i_s_tkeep(s_tkeep), .i_s_tstrb(s_tstrb), .i_s_tlast(s_tlast),
    .i_s_tid(s_tid), .i_s_tdest(s_tdest), .i_s_tuser(s_tuser), .o_m_tvalid(n_tvalid),
    .i_m_tready(stall), .o_m_tdata(n_tdata), .o_m_tkeep(n_tkeep), .o_m_tstrb(n_tstrb),
    .o_m_tlast(n_tlast), .o_m_tid(n_tid), .o_m_tdest(n_tdest), .o_m_tuser(n_tuser),
    .i_err_clr(err_clr), .o_err_null_bytes(), .o_warn_strb_rem(), .o_in_packet(n_in_pkt),
    .o_beat_count(n_beat_cnt), .o_pkt_count(n_pkt_cnt));

  sps_sink #(.W(BW)) i_sps_sink (.i_mclk(mclk), .i_stall(stall), .i_valid(m_tvalid),
    .i_beat({m_tuser, m_tdest, m_tid, m_tlast, m_tstrb, m_tkeep, m_tdata}), .o_ready(m_tready));

  initial
  begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
    total_checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  // Bounded wait at falling edges for the port to accept again
  task automatic wait_ready();
    int n;
    n = 0;
    while (s_tready !== 1'h1)
    begin
      @(negedge mclk);
      n++;
      if (n > 50)
      begin
        n_fail++;
        conclude();
      end
    end
  endtask : wait_ready

  // Offer one beat and hold it until the edge that takes it
  task automatic send(input logic [31:0] d, input logic [3:0] k, input logic [3:0] s,
                      input logic l);
    @(negedge mclk);
    s_tvalid = 1'h1;
    s_tdata  = d;
    s_tkeep  = k;
    s_tstrb  = s;
    s_tlast  = l;
    s_tid    = d[3:0];
    s_tdest  = d[7:4];
    s_tuser  = d[8];
    exp_q.push_back({d[8], d[7:4], d[3:0], l, s, k, d});
    wait_ready();
    @(posedge mclk);
    n_sent++;
  endtask : send

  task automatic idle(input int n);
    @(negedge mclk);
    s_tvalid = 1'h0;
    repeat (n) @(negedge mclk);
  endtask : idle

  task automatic drain();
    int n;
    n = 0;
    while (i_sps_sink.got_q.size() < exp_q.size() && n < 50)
    begin
      @(negedge mclk);
      n++;
    end
    check("beats out", i_sps_sink.got_q.size(), exp_q.size());
    while (exp_q.size() > 0 && i_sps_sink.got_q.size() > 0)
      check("beat", i_sps_sink.got_q.pop_front(), exp_q.pop_front());
    exp_q.delete();
    i_sps_sink.got_q.delete();
  endtask : drain

  task automatic t_reset();
    nrst = 1'h0;
    repeat (4) @(negedge mclk);
    check("ready in reset", s_tready, 1'h0);
    check("valid in reset", m_tvalid, 1'h0);
    check("beats in reset", beat_cnt, 32'h0000_0000);
    nrst = 1'h1;
    @(negedge mclk);
    check("ready after reset", s_tready, 1'h1);
  endtask : t_reset

  task automatic t_packet();
    for (int i = 0; i < 4; i++)
      send(32'h1234_5600 + i, 4'hf, 4'hf, i == 3);
    idle(1);
    drain();
    check("beat count", beat_cnt, 32'h0000_0004);
    check("packet count", pkt_cnt, 32'h0000_0001);
    check("in packet", in_pkt, 1'h0);
  endtask : t_packet

  // Receiver stalls: two beats fill the buffer, then the input must refuse
  task automatic t_stall();
    @(negedge mclk);
    stall = 1'h1;
    send(32'h0000_0aa1, 4'hf, 4'hf, 1'h0);
    send(32'h0000_0bb2, 4'hf, 4'hf, 1'h0);
    idle(0);
    check("ready when full", s_tready, 1'h0);
    check("held valid", m_tvalid, 1'h1);
    check("held data", m_tdata, 32'h0000_0aa1);
    check("in packet", in_pkt, 1'h1);
    stall = 1'h0;
    wait_ready();
    send(32'h0000_0cc3, 4'hf, 4'hf, 1'h1);
    idle(1);
    drain();
    check("packet count", pkt_cnt, 32'h0000_0002);
  endtask : t_stall

  task automatic flag_step(input logic [3:0] k, input logic [3:0] s, input logic l,
                           input logic e_null, input logic e_warn);
    send(32'h0000_0055, k, s, l);
    if (!l)
      send(32'h0000_0066, 4'hf, 4'hf, 1'h1);
    idle(2);
    check("null flag", err_null, e_null);
    check("strobe flag", warn_rem, e_warn);
    err_clr = 1'h1;
    @(negedge mclk);
    err_clr = 1'h0;
    @(negedge mclk);
    check("flags cleared", {err_null, warn_rem}, 2'h0);
  endtask : flag_step

  task automatic t_flags();
    flag_step(4'h7, 4'h7, 1'h0, 1'h1, 1'h0);
    flag_step(4'he, 4'he, 1'h1, 1'h1, 1'h0);
    flag_step(4'h3, 4'h3, 1'h1, 1'h0, 1'h0);
    flag_step(4'h3, 4'h1, 1'h1, 1'h0, 1'h1);
    drain();
  endtask : t_flags

  task automatic t_min();
    send(32'hffff_ffff, 4'h5, 4'h5, 1'h1);
    @(negedge mclk);
    s_tvalid = 1'h0;
    check("min valid", n_tvalid, 1'h1);
    check("min ready", n_tready, 1'h1);
    check("min data", n_tdata, 32'h0000_0000);
    check("min keep strb", {n_tkeep, n_tstrb}, 8'hff);
    check("min last", n_tlast, 1'h0);
    check("min id dest user", {n_tid, n_tdest, n_tuser}, 9'h000);
    idle(1);
    check("min in packet", n_in_pkt, 1'h0);
    check("min packets", n_pkt_cnt, 32'h0000_0000);
    check("min beats", n_beat_cnt, n_sent);
    drain();
  endtask : t_min

  initial
  begin
    {nrst, s_tvalid, s_tlast, err_clr, stall, s_tuser} = 6'h00;
    {s_tdata, s_tkeep, s_tstrb, s_tid, s_tdest} = 48'h0000_0000_0000;
    {n_fail, total_checks, n_sent} = {3{32'h0000_0000}};
    t_reset();
    t_packet();
    t_stall();
    t_flags();
    t_min();
    conclude();
  end
endmodule : test_sps_port
